// ==== hdl/dfcb_pkg.sv ====
/*
 dfcb_pkg: constants for the dac filter coefficient bank (register map, field positions,
 reset values, processing chain table, fixed-point format).
 assumes an apb slave with 32-bit data; each 8-bit coefficient register takes one word.
*/
package dfcb_pkg;
   // byte address = {page[3:0], 1'b0, reg[6:0]} * 4
   localparam int unsigned ADDR_W = 13;
   localparam logic [3:0] PAGE_CTRL = 4'h8;
   localparam logic [3:0] PAGE_BANK_A_FIRST = 4'h8;
   localparam logic [3:0] PAGE_BANK_B_FIRST = 4'hc;
   localparam logic [6:0] REG_ADAPT_CTRL = 7'h01;
   localparam logic [6:0] REG_COEFF_FIRST = 7'h02;
   localparam logic [6:0] REG_DAC_POWER = 7'h00;
   localparam logic [6:0] REG_CHAIN_SEL = 7'h01;
   localparam logic [6:0] REG_CHAIN_INFO = 7'h02;
   localparam logic [3:0] PAGE_DAC_CFG = 4'h0;
   localparam int unsigned BIT_SWITCH_REQ = 0;
   localparam int unsigned BIT_ACTIVE_BANK = 1;
   localparam int unsigned BIT_ADAPT_EN = 2;
   localparam int unsigned BIT_PWR_LEFT = 7;
   localparam int unsigned BIT_PWR_RIGHT = 6;
   // iir taps, index within bank (byte offset from page 8 reg 0)
   localparam logic [8:0] IIR_L_N0 = 9'h082;
   localparam logic [8:0] IIR_L_N1 = 9'h084;
   localparam logic [8:0] IIR_L_D1 = 9'h086;
   localparam logic [8:0] IIR_R_N0 = 9'h088;
   localparam logic [8:0] IIR_R_N1 = 9'h08a;
   localparam logic [8:0] IIR_R_D1 = 9'h08c;
   localparam logic [15:0] TAP0_RESET = 16'h7fff;
   localparam logic [15:0] TAP_ZERO_RESET = 16'h0000;
   localparam int unsigned FRAC_BITS = 15;
   localparam int unsigned NUM_CHAINS = 25;
   typedef enum logic [1:0] {
      DFCB_INTERP_A = 2'b00,
      DFCB_INTERP_B = 2'b01,
      DFCB_INTERP_C = 2'b10
   } dfcb_interp_t;
   // chain word: {interp[1:0], left_only, iir, biquads[2:0], compressor, three_d, beep}
   typedef logic [9:0] dfcb_chain_t;
   function automatic dfcb_chain_t dfcb_chain_lookup(input logic [4:0] idx);
      dfcb_chain_t c;
      c = 10'h000;
      case (idx)
         5'd1: c = {2'b00, 1'b0, 1'b0, 3'd3, 3'b000};
         5'd2: c = {2'b00, 1'b0, 1'b1, 3'd6, 3'b100};
         5'd3: c = {2'b00, 1'b0, 1'b1, 3'd6, 3'b000};
         5'd4: c = {2'b00, 1'b1, 1'b0, 3'd3, 3'b000};
         5'd5: c = {2'b00, 1'b1, 1'b1, 3'd6, 3'b100};
         5'd6: c = {2'b00, 1'b1, 1'b1, 3'd6, 3'b000};
         5'd7: c = {2'b01, 1'b0, 1'b1, 3'd0, 3'b000};
         5'd8: c = {2'b01, 1'b0, 1'b0, 3'd4, 3'b100};
         5'd9: c = {2'b01, 1'b0, 1'b0, 3'd4, 3'b000};
         5'd10: c = {2'b01, 1'b0, 1'b1, 3'd6, 3'b100};
         5'd11: c = {2'b01, 1'b0, 1'b1, 3'd6, 3'b000};
         5'd12: c = {2'b01, 1'b1, 1'b1, 3'd0, 3'b000};
         5'd13: c = {2'b01, 1'b1, 1'b0, 3'd4, 3'b100};
         5'd14: c = {2'b01, 1'b1, 1'b0, 3'd4, 3'b000};
         5'd15: c = {2'b01, 1'b1, 1'b1, 3'd6, 3'b100};
         5'd16: c = {2'b01, 1'b1, 1'b1, 3'd6, 3'b000};
         5'd17: c = {2'b10, 1'b0, 1'b1, 3'd0, 3'b000};
         5'd18: c = {2'b10, 1'b0, 1'b1, 3'd4, 3'b100};
         5'd19: c = {2'b10, 1'b0, 1'b1, 3'd4, 3'b000};
         5'd20: c = {2'b10, 1'b1, 1'b1, 3'd0, 3'b000};
         5'd21: c = {2'b10, 1'b1, 1'b1, 3'd4, 3'b100};
         5'd22: c = {2'b10, 1'b1, 1'b1, 3'd4, 3'b000};
         5'd23: c = {2'b00, 1'b0, 1'b0, 3'd2, 3'b010}; // three_d_chain
         5'd24: c = {2'b00, 1'b0, 1'b1, 3'd5, 3'b110};
         5'd25: c = {2'b00, 1'b0, 1'b1, 3'd5, 3'b111}; // full_effects_chain
         default: c = 10'h000;
      endcase
      return c;
   endfunction : dfcb_chain_lookup
endpackage : dfcb_pkg

// ==== hdl/dfcb_top.sv ====
/*
 dfcb_top: double-buffered coefficient banks with adaptive switching, chain selection
 and a stereo first-order iir datapath running on sample strobes.
 assumes an apb master, samples arriving with a one-cycle i_sample_stb per period.
*/
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dfcb_top #(
   // four pages of 128 byte registers per bank; the 9-bit bank offset spans all of them
   parameter int unsigned BANK_BYTES = 512
) (
   input wire logic i_core_clk, // 10 mhz core clock
   input wire logic i_rst_n, // synchronous reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [14:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire logic i_sample_stb, // start of a sampling period
   input wire logic signed [15:0] i_left, // left input sample
   input wire logic signed [15:0] i_right, // right input sample
   output logic signed [15:0] o_left, // left iir output
   output logic signed [15:0] o_right, // right iir output
   output logic o_dac_running, // either dac channel powered
   output logic o_active_bank, // bank in use, 1 = b
   output logic [9:0] o_chain_cfg // decoded processing chain
);
   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] bank_a [BANK_BYTES];
   logic [7:0] bank_b [BANK_BYTES];
   logic adapt_en_r;
   logic switch_req_r;
   logic active_bank_r;
   logic pwr_left_r;
   logic pwr_right_r;
   logic [4:0] chain_sel_r;
   logic signed [15:0] x_l_r, x_r_r;
   logic signed [15:0] y_l_r, y_r_r;
   logic [3:0] page;
   logic [6:0] reg_idx;
   logic access;
   logic is_coeff;
   logic coeff_blocked;
   logic target_b;
   logic [8:0] boff;
   logic swap;

   assign page = paddr[13:10];
   assign reg_idx = paddr[8:2];
   assign access = psel & penable;
   assign pready = 1'b1;
   assign o_dac_running = pwr_left_r | pwr_right_r;
   assign o_active_bank = active_bank_r;
   assign o_chain_cfg = dfcb_pkg::dfcb_chain_lookup(chain_sel_r);
   // pages 8..15 hold both banks; each page carries 128 registers
   assign is_coeff = (paddr[14] == 1'b0) && page[3] && !(page == dfcb_pkg::PAGE_CTRL &&
      reg_idx < dfcb_pkg::REG_COEFF_FIRST) && (paddr[1:0] == 2'b00);
   assign boff = {page[1:0], reg_idx};
   assign coeff_blocked = o_dac_running & ~adapt_en_r;
   // running: always the idle bank; stopped: the addressed one
   assign target_b = o_dac_running ? ~active_bank_r : page[2];
   // swap only when running in adaptive mode
   assign swap = switch_req_r & adapt_en_r & o_dac_running & i_sample_stb;

   ////////////////////////////////////////////////////////////////////////////
   // unmapped or locked accesses answer with pslverr
   function automatic logic is_ctrl(input logic [14:0] a);
      return a[14] == 1'b0 && a[13:10] == dfcb_pkg::PAGE_CTRL &&
         a[8:2] == dfcb_pkg::REG_ADAPT_CTRL && a[1:0] == 2'b00;
   endfunction : is_ctrl

   function automatic logic is_cfg(input logic [14:0] a);
      return a[14] == 1'b0 && a[13:10] == dfcb_pkg::PAGE_DAC_CFG && a[1:0] == 2'b00 &&
         (a[8:2] == dfcb_pkg::REG_DAC_POWER || a[8:2] == dfcb_pkg::REG_CHAIN_SEL ||
         a[8:2] == dfcb_pkg::REG_CHAIN_INFO);
   endfunction : is_cfg

   always_comb
   begin
      pslverr = 1'b0;
      if (access)
      begin
         if (is_coeff)
            pslverr = coeff_blocked;
         else if (!is_ctrl(paddr) && !is_cfg(paddr))
            pslverr = 1'b1;
         else if (is_cfg(paddr) && pwrite && paddr[8:2] == dfcb_pkg::REG_CHAIN_INFO)
            pslverr = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data registered at the access edge would cost a wait state; decode combinationally
   always_comb
   begin
      prdata = 32'h0000_0000;
      if (access && !pwrite)
      begin
         if (is_coeff && !coeff_blocked)
            prdata = {24'h00_0000, page[2] ? bank_b[boff] : bank_a[boff]};
         else if (is_ctrl(paddr))
            prdata = {29'h0000_0000, adapt_en_r, active_bank_r, switch_req_r};
         else if (is_cfg(paddr) && paddr[8:2] == dfcb_pkg::REG_DAC_POWER)
            prdata = {24'h00_0000, pwr_left_r, pwr_right_r, 6'h00};
         else if (is_cfg(paddr) && paddr[8:2] == dfcb_pkg::REG_CHAIN_SEL)
            prdata = {27'h000_0000, chain_sel_r};
         else if (is_cfg(paddr))
            prdata = {22'h00_0000, o_chain_cfg};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // coefficient store; 16-bit taps stored msb first in consecutive bytes
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         for (int i = 0; i < BANK_BYTES; i++)
         begin
            bank_a[i] <= 8'h00;
            bank_b[i] <= 8'h00;
         end
         for (int k = 0; k < 2; k++)
         begin
            // n0 flat, n1 and d1 zero
            bank_a[dfcb_pkg::IIR_L_N0 + 9'(6 * k)] <= dfcb_pkg::TAP0_RESET[15:8];
            bank_a[dfcb_pkg::IIR_L_N0 + 9'(6 * k + 1)] <= dfcb_pkg::TAP0_RESET[7:0];
            bank_b[dfcb_pkg::IIR_L_N0 + 9'(6 * k)] <= dfcb_pkg::TAP0_RESET[15:8];
            bank_b[dfcb_pkg::IIR_L_N0 + 9'(6 * k + 1)] <= dfcb_pkg::TAP0_RESET[7:0];
         end
         for (int q = 0; q < 12; q++)
         begin
            // biquad n0 taps reset to unity on both channels
            bank_a[9'(2 + 10 * (q % 6) + 64 * (q / 6))] <= dfcb_pkg::TAP0_RESET[15:8];
            bank_a[9'(3 + 10 * (q % 6) + 64 * (q / 6))] <= dfcb_pkg::TAP0_RESET[7:0];
            bank_b[9'(2 + 10 * (q % 6) + 64 * (q / 6))] <= dfcb_pkg::TAP0_RESET[15:8];
            bank_b[9'(3 + 10 * (q % 6) + 64 * (q / 6))] <= dfcb_pkg::TAP0_RESET[7:0];
         end
      end
      else if (access && pwrite && is_coeff && !coeff_blocked)
      begin
         if (target_b)
            bank_b[boff] <= pwdata[7:0];
         else
            bank_a[boff] <= pwdata[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // adaptive control register
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         adapt_en_r <= 1'b0;
         switch_req_r <= 1'b0;
      end
      else
      begin
         if (access && pwrite && is_ctrl(paddr))
            adapt_en_r <= pwdata[dfcb_pkg::BIT_ADAPT_EN];
         // a new request in the swap cycle wins over the self clear
         if (access && pwrite && is_ctrl(paddr) && pwdata[dfcb_pkg::BIT_SWITCH_REQ])
            switch_req_r <= 1'b1;
         else if (swap || (switch_req_r && !(adapt_en_r && o_dac_running)))
            switch_req_r <= 1'b0;
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
         active_bank_r <= 1'b0;
      else if (swap)
         active_bank_r <= ~active_bank_r;
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         pwr_left_r <= 1'b0;
         pwr_right_r <= 1'b0;
         chain_sel_r <= 5'h01;
      end
      else if (access && pwrite && is_cfg(paddr))
      begin
         if (paddr[8:2] == dfcb_pkg::REG_DAC_POWER)
         begin
            pwr_left_r <= pwdata[dfcb_pkg::BIT_PWR_LEFT];
            pwr_right_r <= pwdata[dfcb_pkg::BIT_PWR_RIGHT];
         end
         else if (paddr[8:2] == dfcb_pkg::REG_CHAIN_SEL && pwdata[4:0] != 5'h00 &&
            pwdata[4:0] <= 5'(dfcb_pkg::NUM_CHAINS))
            chain_sel_r <= pwdata[4:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // first-order iir in 1.15; biquads are not built here, their taps only stored
   function automatic logic signed [15:0] dfcb_tap(input logic bank_sel, input logic [8:0] a);
      return bank_sel ? $signed({bank_b[a], bank_b[a + 9'd1]}) :
         $signed({bank_a[a], bank_a[a + 9'd1]});
   endfunction : dfcb_tap

   function automatic logic signed [15:0] dfcb_iir(input logic signed [15:0] x,
      input logic signed [15:0] xd, input logic signed [15:0] yd,
      input logic signed [15:0] n0, input logic signed [15:0] n1,
      input logic signed [15:0] d1);
      logic signed [33:0] acc;
      acc = 34'(n0 * x) + 34'(n1 * xd) + 34'(d1 * yd);
      acc = acc >>> dfcb_pkg::FRAC_BITS;
      if (acc > 34'sd32767)
         return 16'sh7fff;
      else if (acc < -34'sd32768)
         return 16'sh8000;
      else
         return acc[15:0];
   endfunction : dfcb_iir

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         x_l_r <= 16'sh0000;
         x_r_r <= 16'sh0000;
         y_l_r <= 16'sh0000;
         y_r_r <= 16'sh0000;
         o_left <= 16'sh0000;
         o_right <= 16'sh0000;
      end
      else if (i_sample_stb && o_dac_running)
      begin
         x_l_r <= i_left;
         y_l_r <= dfcb_iir(i_left, x_l_r, y_l_r, dfcb_tap(active_bank_r, dfcb_pkg::IIR_L_N0),
            dfcb_tap(active_bank_r, dfcb_pkg::IIR_L_N1), dfcb_tap(active_bank_r, dfcb_pkg::IIR_L_D1));
         o_left <= dfcb_iir(i_left, x_l_r, y_l_r, dfcb_tap(active_bank_r, dfcb_pkg::IIR_L_N0),
            dfcb_tap(active_bank_r, dfcb_pkg::IIR_L_N1), dfcb_tap(active_bank_r, dfcb_pkg::IIR_L_D1));
         x_r_r <= i_right;
         y_r_r <= dfcb_iir(i_right, x_r_r, y_r_r, dfcb_tap(active_bank_r, dfcb_pkg::IIR_R_N0),
            dfcb_tap(active_bank_r, dfcb_pkg::IIR_R_N1), dfcb_tap(active_bank_r, dfcb_pkg::IIR_R_D1));
         o_right <= dfcb_iir(i_right, x_r_r, y_r_r, dfcb_tap(active_bank_r, dfcb_pkg::IIR_R_N0),
            dfcb_tap(active_bank_r, dfcb_pkg::IIR_R_N1), dfcb_tap(active_bank_r, dfcb_pkg::IIR_R_D1));
      end
   end
endmodule : dfcb_top
`default_nettype wire

// ==== sim/dfcb_apb_host.sv ====
/*
 dfcb_apb_host: apb master model of the host programming the coefficient banks.
 assumes one caller at a time; gives up after 16 access cycles without pready.
*/
`timescale 1ns/1ps
`default_nettype none
module dfcb_apb_host (
   input wire logic i_core_clk, // clock
   input wire logic pready, // slave ready
   input wire logic [31:0] prdata, // read data
   input wire logic pslverr, // slave error
   output logic psel, // select
   output logic penable, // enable
   output logic pwrite, // direction
   output logic [14:0] paddr, // byte address
   output logic [31:0] pwdata // write data
);
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 15'h0000;
      pwdata = 32'h0;
   end
   ////////////////////////////////////////////////////////////////////////////////////////
   // one byte register per transfer, so a coefficient takes two calls
   task automatic xfer(input logic w, input logic [14:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e, output logic t);
      int n;
      @(posedge i_core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_core_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge i_core_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      t = (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
endmodule : dfcb_apb_host
`default_nettype wire

// ==== sim/dfcb_checker.sv ====
/*
 dfcb_checker: port-level assertions for dfcb_top.
 assumes one clock domain, zero-wait apb and the register map of dfcb_pkg.
*/
`timescale 1ns/1ps
`default_nettype none
module dfcb_checker #(
   parameter int unsigned BANK_BYTES = 512
) (
   input wire logic i_core_clk, // clock
   input wire logic i_rst_n, // reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [14:0] paddr, // apb address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic [31:0] prdata, // apb read data
   input wire logic pslverr, // apb error
   input wire logic i_sample_stb, // sample strobe
   input wire logic signed [15:0] o_left, // left output
   input wire logic signed [15:0] o_right, // right output
   input wire logic o_dac_running, // running flag
   input wire logic o_active_bank // bank in use
);
   logic acc_on, wr_ctrl, coef, adapt_r, pend_r;
   assign acc_on = psel && penable;
   assign wr_ctrl = acc_on && pwrite && paddr == 15'h2004;
   // regs 0-1 of pages 8 and 12 are excluded; in dfcb_top only those of page 8 are not coefficients
   assign coef = !paddr[14] && !paddr[9] && paddr[13] && {paddr[11:10], paddr[8:2]} >= 9'h002
      && {paddr[11:10], paddr[8:2]} < BANK_BYTES;
   // shadow of the adaptive enable and the pending swap, as software sees them
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         adapt_r <= 1'b0;
         pend_r <= 1'b0;
      end
      else
      begin
         if (wr_ctrl)
            adapt_r <= pwdata[2];
         if (wr_ctrl && pwdata[0] && pwdata[2] && o_dac_running)
            pend_r <= 1'b1;
         else if (i_sample_stb || !o_dac_running || (wr_ctrl && !pwdata[2]))
            pend_r <= 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rst_n);
   sequence s_swap_due;
      pend_r && adapt_r && o_dac_running && i_sample_stb;
   endsequence
   sequence s_ctrl_read;
      acc_on && !pwrite && paddr == 15'h2004;
   endsequence
   property p_locked;
      acc_on && coef && o_dac_running && !adapt_r |-> pslverr && prdata == 32'h0;
   endproperty
   a_locked: assert property (p_locked) else $error("locked coefficient accepted");
   property p_open;
      acc_on && coef && (!o_dac_running || adapt_r) |-> !pslverr;
   endproperty
   a_open: assert property (p_open) else $error("open coefficient refused");
   property p_unmapped;
      acc_on && !paddr[13] && paddr[12:10] != 3'h0 |-> pslverr;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped page accepted");
   property p_info_ro;
      acc_on && pwrite && paddr == 15'h0008 |-> pslverr;
   endproperty
   a_info_ro: assert property (p_info_ro) else $error("chain info write accepted");
   property p_power;
      acc_on && pwrite && paddr == 15'h0000 |=>
         o_dac_running == ($past(pwdata[7]) || $past(pwdata[6]));
   endproperty
   a_power: assert property (p_power) else $error("running flag wrong");
   property p_swap;
      s_swap_due |=> o_active_bank != $past(o_active_bank);
   endproperty
   a_swap: assert property (p_swap) else $error("bank did not swap");
   property p_noswap;
      i_sample_stb && (!adapt_r || !o_dac_running) |=> $stable(o_active_bank);
   endproperty
   a_noswap: assert property (p_noswap) else $error("bank swapped unasked");
   property p_hold_bank;
      !i_sample_stb |=> $stable(o_active_bank);
   endproperty
   a_hold_bank: assert property (p_hold_bank) else $error("bank moved off strobe");
   property p_ctrl_rd;
      s_ctrl_read |-> prdata[2:0] == {adapt_r, o_active_bank, pend_r};
   endproperty
   a_ctrl_rd: assert property (p_ctrl_rd) else $error("control readback wrong");
   property p_hold_out;
      !i_sample_stb |=> $stable(o_left) && $stable(o_right);
   endproperty
   a_hold_out: assert property (p_hold_out) else $error("output moved off strobe");
endmodule : dfcb_checker
bind dfcb_top dfcb_checker #(.BANK_BYTES(BANK_BYTES)) dfcb_checker_inst (.i_core_clk, .i_rst_n,
   .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr, .i_sample_stb, .o_left, .o_right,
   .o_dac_running, .o_active_bank);
`default_nettype wire

// ==== sim/tb_dfcb_top.sv ====
/*
 tb_dfcb_top: self-checking bench for the coefficient bank block.
 assumes the host model drives apb and the bench drives the sample stream.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_dfcb_top;
   logic i_core_clk, i_rst_n, psel, penable, pwrite, pready, pslverr, i_sample_stb;
   logic o_dac_running, o_active_bank;
   logic [14:0] paddr;
   logic [31:0] pwdata, prdata;
   logic signed [15:0] i_left, i_right, o_left, o_right;
   logic [9:0] o_chain_cfg;
   int n_mismatch, checked;
   typedef struct {logic [4:0] idx; logic [9:0] cfg;} dfcb_row_t;
   dfcb_row_t rows[7] = '{'{5'h01, 10'h018}, '{5'h02, 10'h074}, '{5'h07, 10'h140},
      '{5'h0c, 10'h1c0}, '{5'h11, 10'h240}, '{5'h17, 10'h012}, '{5'h19, 10'h06f}};
   initial
   begin
      i_core_clk = 1'b0;
      forever #50 i_core_clk = ~i_core_clk;
   end
   dfcb_top #(.BANK_BYTES(512)) dfcb_top_inst (.i_core_clk, .i_rst_n, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .i_sample_stb, .i_left, .i_right, .o_left,
      .o_right, .o_dac_running, .o_active_bank, .o_chain_cfg);
   dfcb_apb_host dfcb_apb_host_inst (.i_core_clk, .pready, .prdata, .pslverr, .psel, .penable,
      .pwrite, .paddr, .pwdata);
   ////////////////////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("mismatches %0d comparisons %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : complete_run
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: value %h, expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic cmp_flag(input logic got, input logic exp);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: flag %b, expected %b", $time, got, exp);
      end
   endtask : cmp_flag
   // for a read, d is the byte expected back
   task automatic acc(input logic w, input logic [3:0] pg, input logic [6:0] rg,
      input logic [7:0] d, input logic ee);
      logic [31:0] q;
      logic e, t;
      dfcb_apb_host_inst.xfer(w, {1'b0, pg, 1'b0, rg, 2'b00}, {24'h0, d}, q, e, t);
      if (t)
      begin
         n_mismatch++;
         complete_run();
      end
      else
      begin
         cmp_flag(e, ee);
         if (!w)
            cmp(q, {24'h0, d});
      end
   endtask : acc
   task automatic strobe(input logic signed [15:0] x);
      @(posedge i_core_clk);
      i_sample_stb <= 1'b1;
      i_left <= x;
      i_right <= x;
      @(posedge i_core_clk);
      i_sample_stb <= 1'b0;
      @(posedge i_core_clk);
   endtask : strobe
   ////////////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      i_rst_n = 1'b0;
      i_sample_stb = 1'b0;
      i_left = 16'sh0000;
      i_right = 16'sh0000;
      n_mismatch = 0;
      checked = 0;
      repeat (2) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      @(posedge i_core_clk);
      cmp_flag(o_active_bank, 1'b0);
      cmp_flag(o_dac_running, 1'b0);
      cmp_flag(pready, 1'b1);
      acc(1'b0, 4'h9, 7'h02, 8'h7f, 1'b0);
      acc(1'b0, 4'h9, 7'h03, 8'hff, 1'b0);
      acc(1'b0, 4'h9, 7'h08, 8'h7f, 1'b0);
      acc(1'b0, 4'h9, 7'h0c, 8'h00, 1'b0);
      foreach (rows[i])
      begin
         acc(1'b1, 4'h0, 7'h01, {3'h0, rows[i].idx}, 1'b0);
         @(posedge i_core_clk);
         cmp({22'h0, o_chain_cfg}, {22'h0, rows[i].cfg});
      end
      acc(1'b1, 4'h0, 7'h02, 8'h00, 1'b1);
      acc(1'b0, 4'h1, 7'h00, 8'h00, 1'b1);
      acc(1'b1, 4'hd, 7'h02, 8'h20, 1'b0);
      acc(1'b1, 4'hd, 7'h03, 8'h00, 1'b0);
      acc(1'b1, 4'h9, 7'h02, 8'h40, 1'b0);
      acc(1'b1, 4'h9, 7'h03, 8'h00, 1'b0);
      acc(1'b0, 4'hd, 7'h02, 8'h20, 1'b0);
      acc(1'b0, 4'h9, 7'h02, 8'h40, 1'b0);
      acc(1'b1, 4'h0, 7'h00, 8'h80, 1'b0);
      @(posedge i_core_clk);
      cmp_flag(o_dac_running, 1'b1);
      acc(1'b0, 4'h9, 7'h02, 8'h00, 1'b1);
      acc(1'b1, 4'h9, 7'h04, 8'h11, 1'b1);
      acc(1'b1, 4'h8, 7'h01, 8'h04, 1'b0);
      acc(1'b0, 4'h9, 7'h04, 8'h00, 1'b0);
      acc(1'b1, 4'h8, 7'h02, 8'h12, 1'b0);
      acc(1'b0, 4'hc, 7'h02, 8'h12, 1'b0);
      acc(1'b0, 4'h8, 7'h02, 8'h7f, 1'b0);
      strobe(16'sh1000);
      cmp({16'h0, o_left}, 32'h0000_0800);
      cmp({16'h0, o_right}, 32'h0000_0fff);
      acc(1'b1, 4'h8, 7'h01, 8'h05, 1'b0);
      acc(1'b0, 4'h8, 7'h01, 8'h05, 1'b0);
      strobe(16'sh1000);
      cmp_flag(o_active_bank, 1'b1);
      acc(1'b0, 4'h8, 7'h01, 8'h06, 1'b0);
      strobe(16'sh1000);
      cmp({16'h0, o_left}, 32'h0000_0400);
      acc(1'b1, 4'hc, 7'h02, 8'h33, 1'b0);
      acc(1'b0, 4'h8, 7'h02, 8'h33, 1'b0);
      acc(1'b1, 4'h8, 7'h01, 8'h01, 1'b0);
      strobe(16'sh0000);
      cmp_flag(o_active_bank, 1'b1);
      acc(1'b0, 4'h8, 7'h01, 8'h02, 1'b0);
      // second reset in mid-run: state and taps must return to their reset values
      acc(1'b1, 4'h0, 7'h01, 8'h19, 1'b0);
      @(posedge i_core_clk);
      i_rst_n <= 1'b0;
      repeat (2) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      @(posedge i_core_clk);
      cmp_flag(o_active_bank, 1'b0);
      cmp_flag(o_dac_running, 1'b0);
      cmp({22'h0, o_chain_cfg}, 32'h0000_0018);
      acc(1'b0, 4'h9, 7'h02, 8'h7f, 1'b0);
      acc(1'b0, 4'hd, 7'h02, 8'h7f, 1'b0);
      acc(1'b0, 4'h8, 7'h02, 8'h7f, 1'b0);
      acc(1'b1, 4'hb, 7'h7e, 8'h5a, 1'b0);
      acc(1'b0, 4'hb, 7'h7e, 8'h5a, 1'b0);
      complete_run();
   end
endmodule : tb_dfcb_top
`default_nettype wire
